// file: inc/mcfg_pkg.sv
// Shared constants and carriers of the MCU configuration register bank.
// Assumes an 8-bit MCU bus already qualified by a decoded window select.
package mcfg_pkg;

   // ==========================================================
   // Window and port geometry
   // ==========================================================
   localparam int          NUM_PORTS   = 7;
   localparam int          PORT_WIDTH  = 8;
   localparam int          WINDOW_SIZE = 256;
   localparam int          NUM_CELLS   = 16;
   localparam int          NUM_COMB    = 8;
   localparam int          NUM_TEST    = 6;
   localparam int          TEST_IN     = 3;

   // ==========================================================
   // Register offsets, index 0 is port A, index 6 is port G
   // ==========================================================
   localparam logic [6:0][7:0] OFF_PIN_IN  =
      {8'h41, 8'h40, 8'h30, 8'h11, 8'h10, 8'h01, 8'h00};
   localparam logic [6:0][7:0] OFF_FUNC    =
      {8'h43, 8'h42, 8'h32, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [6:0][7:0] OFF_LATCH   =
      {8'h45, 8'h44, 8'h34, 8'h15, 8'h14, 8'h05, 8'h04};
   localparam logic [6:0][7:0] OFF_DIR     =
      {8'h47, 8'h46, 8'h36, 8'h15, 8'h14, 8'h07, 8'h06};
   localparam logic [6:0][7:0] OFF_DRIVE   =
      {8'h49, 8'h48, 8'h38, 8'h19, 8'h18, 8'h09, 8'h08};
   localparam logic [6:0][7:0] OFF_CELLS_IN =
      {8'h00, 8'h00, 8'h00, 8'h1A, 8'h00, 8'h0B, 8'h0A};
   localparam logic [6:0][7:0] OFF_DRV_EN  =
      {8'h00, 8'h4C, 8'h00, 8'h1B, 8'h1C, 8'h0D, 8'h0C};
   localparam logic [6:0]      HAS_FUNC     = 7'h70;
   localparam logic [6:0]      HAS_CELLS_IN = 7'h0B;
   localparam logic [6:0]      HAS_DRV_EN   = 7'h2F;
   localparam logic [6:0]      OPEN_DRAIN   = 7'h5B;
   localparam int              PORT_C       = 2;
   localparam int              PORT_E       = 4;
   localparam int              PORT_F       = 5;
   localparam int              PORT_A       = 0;

   localparam logic [7:0] OFF_CELLS_A  = 8'h20;
   localparam logic [7:0] OFF_CELLS_B  = 8'h21;
   localparam logic [7:0] OFF_BLOCK_A  = 8'h22;
   localparam logic [7:0] OFF_BLOCK_B  = 8'h23;
   localparam logic [7:0] OFF_PWR_ZERO = 8'hB0;
   localparam logic [7:0] OFF_PWR_TWO  = 8'hB4;
   localparam logic [7:0] OFF_MAIN_LCK = 8'hC0;
   localparam logic [7:0] OFF_BOOT_LCK = 8'hC2;
   localparam logic [7:0] OFF_TEST_EN  = 8'hC7;

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int         PWR0_APD_EN  = 1;
   localparam int         PWR0_TURBO   = 3;
   localparam int         PWR2_STROBES = 7;
   localparam logic [7:0] PWR_ZERO_RST = 8'h08;
   localparam logic [7:0] REG_RST      = 8'h00;
   localparam logic [1:0] BUSCFG_MUX   = 2'h0;
   localparam logic [1:0] BUSCFG_AB    = 2'h1;
   localparam logic [1:0] BUSCFG_FG    = 2'h2;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLOCK_NS     = 100;
   localparam int APD_IDLE_NS  = 1000;
   localparam int APD_CYCLES   = (APD_IDLE_NS + CLOCK_NS - 1) / CLOCK_NS;

   // ==========================================================
   // Types
   // ==========================================================
   typedef struct packed {
      logic       select;
      logic       read;
      logic       write;
      logic [7:0] offset;
      logic [7:0] wdata;
   } mcfg_bus_t;

   typedef struct packed {
      logic [6:0][7:0] level;
      logic [6:0][7:0] oe_n;
   } mcfg_pins_t;

   typedef enum logic [2:0] {
      PWR_RUN   = 3'b001,
      PWR_SLEEP = 3'b010,
      PWR_DOWN  = 3'b100
   } mcfg_pwr_t;

endpackage

// file: design/mcfg_bank.sv
// Configuration and status register bank with port pin control.
// Assumes bus strobes on i_clock, pins asynchronous to it.
`timescale 1ns/1ps
`default_nettype none

module mcfg_bank (
   input  wire logic                 i_clock,
   input  wire logic                 i_reset,
   input  wire mcfg_pkg::mcfg_bus_t  i_bus,
   input  wire logic [6:0][7:0]      i_pins,
   input  wire logic [7:0]           i_latched_address,
   input  wire logic [15:0]          i_cell_next,
   input  wire logic [7:0]           i_comb_terms,
   input  wire logic [7:0]           i_main_lock,
   input  wire logic [7:0]           i_boot_lock,
   input  wire logic [2:0]           i_test_out,
   input  wire logic [1:0]           i_bus_config,
   output logic [7:0]                o_read_data,
   output mcfg_pkg::mcfg_pins_t      o_pins,
   output logic [1:0][7:0]           o_fast_slew,
   output logic [15:0]               o_cells,
   output logic [7:0]                o_comb_outputs,
   output logic [6:0][7:0]           o_logic_inputs,
   output logic [2:0]                o_logic_strobes,
   output logic [2:0]                o_test_in,
   output logic                      o_power_down
);

   // ==========================================================
   // Decode helpers
   // ==========================================================
   function automatic logic hit(input logic [7:0] off,
                                input logic [7:0] target);
      hit = (off == target);
   endfunction

   logic access;
   logic wr;
   logic rd;
   assign access = i_bus.select;
   assign wr     = access & i_bus.write;
   assign rd     = access & i_bus.read & ~i_bus.write;

   // ==========================================================
   // Pin synchronisers: change accepted when stages 2 and 3 agree
   // ==========================================================
   logic [6:0][7:0] sync1;
   logic [6:0][7:0] sync2;
   logic [6:0][7:0] sync3;
   logic [6:0][7:0] pin_level;

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         sync1     <= '0;
         sync2     <= '0;
         sync3     <= '0;
         pin_level <= '0;
      end else begin
         sync1     <= i_pins;
         sync2     <= sync1;
         sync3     <= sync2;
         pin_level <= (sync2 & sync3) | (pin_level & (sync2 | sync3));
      end
   end

   // ==========================================================
   // Port configuration registers
   // ==========================================================
   logic [6:0][7:0] out_latch;
   logic [6:0][7:0] pin_dir;
   logic [6:0][7:0] drive_sel;
   logic [6:0][7:0] pin_func;

   genvar p;
   generate
      for (p = 0; p < mcfg_pkg::NUM_PORTS; p++) begin : g_port
         always_ff @(posedge i_clock) begin
            if (i_reset) begin
               out_latch[p] <= mcfg_pkg::REG_RST;
               pin_dir[p]   <= mcfg_pkg::REG_RST;
               drive_sel[p] <= mcfg_pkg::REG_RST;
               pin_func[p]  <= mcfg_pkg::REG_RST;
            end else if (wr) begin
               if (hit(i_bus.offset, mcfg_pkg::OFF_LATCH[p])) begin
                  out_latch[p] <= i_bus.wdata;
               end
               // In ports C and D direction shares the latch offset: a write loads both
               if (hit(i_bus.offset, mcfg_pkg::OFF_DIR[p])) begin
                  pin_dir[p] <= i_bus.wdata;
               end
               if (hit(i_bus.offset, mcfg_pkg::OFF_DRIVE[p])) begin
                  drive_sel[p] <= i_bus.wdata;
               end
               if (mcfg_pkg::HAS_FUNC[p] &&
                   hit(i_bus.offset, mcfg_pkg::OFF_FUNC[p])) begin
                  pin_func[p] <= i_bus.wdata;
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // Power, cell-block and test-port registers
   // ==========================================================
   logic [7:0] pwr_zero;
   logic [7:0] pwr_two;
   logic [7:0] block_a;
   logic [7:0] block_b;
   logic [7:0] test_en;

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         pwr_zero <= mcfg_pkg::PWR_ZERO_RST;
         pwr_two  <= mcfg_pkg::REG_RST;
         block_a  <= mcfg_pkg::REG_RST;
         block_b  <= mcfg_pkg::REG_RST;
         test_en  <= mcfg_pkg::REG_RST;
      end else if (wr) begin
         if (hit(i_bus.offset, mcfg_pkg::OFF_PWR_ZERO)) begin
            pwr_zero <= i_bus.wdata;
         end
         if (hit(i_bus.offset, mcfg_pkg::OFF_PWR_TWO)) begin
            pwr_two <= i_bus.wdata;
         end
         if (hit(i_bus.offset, mcfg_pkg::OFF_BLOCK_A)) begin
            block_a <= i_bus.wdata;
         end
         if (hit(i_bus.offset, mcfg_pkg::OFF_BLOCK_B)) begin
            block_b <= i_bus.wdata;
         end
         if (hit(i_bus.offset, mcfg_pkg::OFF_TEST_EN)) begin
            test_en <= i_bus.wdata;
         end
      end
   end

   // Data-port strap caught once after reset; the MCU has no path to it
   logic [1:0] bus_cfg;
   logic       cfg_taken;

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         bus_cfg   <= mcfg_pkg::BUSCFG_MUX;
         cfg_taken <= 1'b0;
      end else if (!cfg_taken) begin
         bus_cfg   <= i_bus_config;
         cfg_taken <= 1'b1;
      end
   end

   // ==========================================================
   // User-logic inputs, gated by power register two
   // ==========================================================
   logic [6:0][7:0] next_logic_inputs;
   logic [2:0]      next_strobes;
   logic            input_change;

   always_comb begin
      for (int i = 0; i < mcfg_pkg::NUM_PORTS; i++) begin
         next_logic_inputs[i] = pwr_two[i] ? 8'h00 : pin_level[i];
      end
      next_strobes = pwr_two[mcfg_pkg::PWR2_STROBES] ? 3'h0 :
                     {i_bus.select, i_bus.read, i_bus.write};
   end

   assign input_change = (next_logic_inputs != o_logic_inputs) ||
                         (next_strobes != o_logic_strobes);

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_logic_inputs  <= '0;
         o_logic_strobes <= 3'h0;
      end else begin
         o_logic_inputs  <= next_logic_inputs;
         o_logic_strobes <= next_strobes;
      end
   end

   // ==========================================================
   // Power state: run, sleep on cleared turbo, auto power-down
   // ==========================================================
   mcfg_pkg::mcfg_pwr_t pwr_state;
   mcfg_pkg::mcfg_pwr_t next_pwr_state;
   logic [7:0]          idle_count;
   logic                idle_done;
   logic                logic_awake;

   assign idle_done = (idle_count >= 8'(mcfg_pkg::APD_CYCLES - 1));

   always_ff @(posedge i_clock) begin
      if (i_reset || access) begin
         idle_count <= 8'h00;
      end else if (!idle_done) begin
         idle_count <= idle_count + 8'h01;
      end
   end

   always_comb begin
      next_pwr_state = pwr_state;
      case (pwr_state)
         mcfg_pkg::PWR_RUN: begin
            if (pwr_zero[mcfg_pkg::PWR0_APD_EN] && idle_done && !access) begin
               next_pwr_state = mcfg_pkg::PWR_DOWN;
            end else if (!pwr_zero[mcfg_pkg::PWR0_TURBO]) begin
               next_pwr_state = mcfg_pkg::PWR_SLEEP;
            end
         end
         mcfg_pkg::PWR_SLEEP: begin
            if (pwr_zero[mcfg_pkg::PWR0_TURBO]) begin
               next_pwr_state = mcfg_pkg::PWR_RUN;
            end else if (pwr_zero[mcfg_pkg::PWR0_APD_EN] && idle_done &&
                         !access) begin
               next_pwr_state = mcfg_pkg::PWR_DOWN;
            end
         end
         mcfg_pkg::PWR_DOWN: begin
            // Any bus access wakes the device
            if (access || !pwr_zero[mcfg_pkg::PWR0_APD_EN]) begin
               next_pwr_state = mcfg_pkg::PWR_RUN;
            end
         end
         default: next_pwr_state = mcfg_pkg::PWR_RUN;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         pwr_state    <= mcfg_pkg::PWR_RUN;
         o_power_down <= 1'b0;
      end else begin
         pwr_state    <= next_pwr_state;
         o_power_down <= (next_pwr_state == mcfg_pkg::PWR_DOWN);
      end
   end

   // Sleeping logic still evaluates once on any input transition
   assign logic_awake = (pwr_state == mcfg_pkg::PWR_RUN) ||
                        ((pwr_state == mcfg_pkg::PWR_SLEEP) && input_change);

   // ==========================================================
   // Registered output cells and combinational outputs
   // ==========================================================
   logic        wr_cells_a;
   logic        wr_cells_b;
   logic [15:0] mcu_load;
   logic [15:0] mcu_value;

   assign wr_cells_a = wr && hit(i_bus.offset, mcfg_pkg::OFF_CELLS_A);
   assign wr_cells_b = wr && hit(i_bus.offset, mcfg_pkg::OFF_CELLS_B);
   assign mcu_load   = {{8{wr_cells_b}} & ~block_b,
                        {8{wr_cells_a}} & ~block_a};
   assign mcu_value  = {i_bus.wdata, i_bus.wdata};

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_cells        <= 16'h0000;
         o_comb_outputs <= 8'h00;
      end else begin
         for (int i = 0; i < mcfg_pkg::NUM_CELLS; i++) begin
            if (mcu_load[i]) begin
               o_cells[i] <= mcu_value[i];
            end else if (logic_awake) begin
               o_cells[i] <= i_cell_next[i];
            end
         end
         if (logic_awake) begin
            o_comb_outputs <= i_comb_terms;
         end
      end
   end

   // ==========================================================
   // Pin drivers
   // ==========================================================
   logic                 reading;
   mcfg_pkg::mcfg_pins_t next_pins;
   logic [6:0]           data_port;

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         reading <= 1'b0;
      end else begin
         reading <= rd;
      end
   end

   always_comb begin
      data_port = 7'h00;
      data_port[mcfg_pkg::PORT_A] = (bus_cfg == mcfg_pkg::BUSCFG_AB);
      data_port[mcfg_pkg::PORT_F] = (bus_cfg == mcfg_pkg::BUSCFG_FG);
      for (int i = 0; i < mcfg_pkg::NUM_PORTS; i++) begin
         for (int b = 0; b < mcfg_pkg::PORT_WIDTH; b++) begin
            next_pins.level[i][b] = 1'b0;
            next_pins.oe_n[i][b]  = 1'b1;
            if (i == mcfg_pkg::PORT_E && b < mcfg_pkg::NUM_TEST &&
                test_en[b]) begin
               if (b >= mcfg_pkg::TEST_IN) begin
                  next_pins.level[i][b] =
                     i_test_out[b - mcfg_pkg::TEST_IN];
                  next_pins.oe_n[i][b]  = 1'b0;
               end
            end else if (data_port[i]) begin
               next_pins.level[i][b] = o_read_data[b];
               next_pins.oe_n[i][b]  = ~reading;
            end else if (mcfg_pkg::HAS_FUNC[i] && pin_func[i][b]) begin
               next_pins.level[i][b] = i_latched_address[b];
               next_pins.oe_n[i][b]  = 1'b0;
            end else if (pin_dir[i][b]) begin
               if (mcfg_pkg::OPEN_DRAIN[i] && drive_sel[i][b]) begin
                  next_pins.oe_n[i][b] = out_latch[i][b];
               end else begin
                  next_pins.level[i][b] = out_latch[i][b];
                  next_pins.oe_n[i][b]  = 1'b0;
               end
            end
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_pins      <= '{level: '0, oe_n: '1};
         o_fast_slew <= '0;
         o_test_in   <= 3'h0;
      end else begin
         o_pins         <= next_pins;
         o_fast_slew[0] <= drive_sel[mcfg_pkg::PORT_C];
         o_fast_slew[1] <= drive_sel[mcfg_pkg::PORT_F];
         for (int b = 0; b < mcfg_pkg::TEST_IN; b++) begin
            o_test_in[b] <= test_en[b] & pin_level[mcfg_pkg::PORT_E][b];
         end
      end
   end

   // ==========================================================
   // Read path: one-cycle answer, unmapped reads as zero
   // ==========================================================
   logic [7:0] next_read;

   always_comb begin
      next_read = 8'h00;
      for (int i = 0; i < mcfg_pkg::NUM_PORTS; i++) begin
         if (hit(i_bus.offset, mcfg_pkg::OFF_PIN_IN[i])) begin
            next_read = pin_level[i];
         end
         if (mcfg_pkg::HAS_FUNC[i] &&
             hit(i_bus.offset, mcfg_pkg::OFF_FUNC[i])) begin
            next_read = pin_func[i];
         end
         if (hit(i_bus.offset, mcfg_pkg::OFF_DIR[i])) begin
            next_read = pin_dir[i];
         end
         if (hit(i_bus.offset, mcfg_pkg::OFF_LATCH[i])) begin
            next_read = out_latch[i];
         end
         if (hit(i_bus.offset, mcfg_pkg::OFF_DRIVE[i])) begin
            next_read = drive_sel[i];
         end
         if (mcfg_pkg::HAS_CELLS_IN[i] &&
             hit(i_bus.offset, mcfg_pkg::OFF_CELLS_IN[i])) begin
            next_read = pin_level[i];
         end
         if (mcfg_pkg::HAS_DRV_EN[i] &&
             hit(i_bus.offset, mcfg_pkg::OFF_DRV_EN[i])) begin
            next_read = ~o_pins.oe_n[i];
         end
      end
      case (i_bus.offset)
         mcfg_pkg::OFF_CELLS_A:  next_read = o_cells[7:0];
         mcfg_pkg::OFF_CELLS_B:  next_read = o_cells[15:8];
         mcfg_pkg::OFF_BLOCK_A:  next_read = block_a;
         mcfg_pkg::OFF_BLOCK_B:  next_read = block_b;
         mcfg_pkg::OFF_PWR_ZERO: next_read = pwr_zero;
         mcfg_pkg::OFF_PWR_TWO:  next_read = pwr_two;
         mcfg_pkg::OFF_MAIN_LCK: next_read = i_main_lock;
         mcfg_pkg::OFF_BOOT_LCK: next_read = i_boot_lock;
         mcfg_pkg::OFF_TEST_EN:  next_read = test_en;
         default: ;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_read_data <= 8'h00;
      end else if (rd) begin
         o_read_data <= next_read;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   chk_unmapped_zero: assert property (@(posedge i_clock) disable iff (i_reset)
      rd && i_bus.offset == 8'hFF |=> o_read_data == 8'h00)
      else $error("unmapped offset did not read zero");

   chk_latch_store: assert property (@(posedge i_clock) disable iff (i_reset)
      wr && i_bus.offset == 8'h04 ##1 !wr ##1 rd && i_bus.offset == 8'h04
      |=> o_read_data == $past(i_bus.wdata, 3))
      else $error("output latch readback mismatch");

   chk_cell_block: assert property (@(posedge i_clock) disable iff (i_reset)
      wr_cells_a && block_a[0] |=> o_cells[0] == $past(o_cells[0])
                                  || $past(logic_awake))
      else $error("blocked cell took an MCU write");

   chk_cell_load: assert property (@(posedge i_clock) disable iff (i_reset)
      wr_cells_b && !block_b[3] |=> o_cells[11] == $past(i_bus.wdata[3]))
      else $error("cell load from MCU lost");

   chk_sleep_hold: assert property (@(posedge i_clock) disable iff (i_reset)
      pwr_state == mcfg_pkg::PWR_SLEEP && !input_change && !wr
      |=> $stable(o_cells) && $stable(o_comb_outputs))
      else $error("sleeping logic changed without input transition");

   chk_turbo_sleep: assert property (@(posedge i_clock) disable iff (i_reset)
      pwr_state == mcfg_pkg::PWR_RUN && !pwr_zero[mcfg_pkg::PWR0_TURBO]
      && !pwr_zero[mcfg_pkg::PWR0_APD_EN]
      |=> pwr_state == mcfg_pkg::PWR_SLEEP)
      else $error("cleared turbo did not enter sleep");

   chk_input_block: assert property (@(posedge i_clock) disable iff (i_reset)
      pwr_two[2] |=> o_logic_inputs[2] == 8'h00)
      else $error("blocked port reached user logic");

   chk_strobe_block: assert property (@(posedge i_clock) disable iff (i_reset)
      pwr_two[mcfg_pkg::PWR2_STROBES] |=> o_logic_strobes == 3'h0)
      else $error("blocked strobes reached user logic");

   chk_apd_wake: assert property (@(posedge i_clock) disable iff (i_reset)
      o_power_down && access |=> !o_power_down)
      else $error("bus access did not leave power-down");

   chk_apd_entry: assert property (@(posedge i_clock) disable iff (i_reset)
      !access [*8] ##1 !access && pwr_zero[mcfg_pkg::PWR0_APD_EN]
      && $stable(pwr_zero) ##1 !access |=> o_power_down)
      else $error("idle bus did not power down");

   chk_drv_status: assert property (@(posedge i_clock) disable iff (i_reset)
      rd && i_bus.offset == 8'h0C |=> o_read_data == ~$past(o_pins.oe_n[0]))
      else $error("driver status read mismatch");

   chk_pin_sync: assert property (@(posedge i_clock) disable iff (i_reset)
      sync2[1] == sync3[1] |=> pin_level[1] == $past(sync2[1]))
      else $error("agreed pin level not taken");

endmodule // mcfg_bank

`default_nettype wire

// file: test/mcfg_board.sv
// Pin board model: external sources meet the bank's pin drivers.
// Assumes the pins struct of the bank; released pins follow i_ext.
`timescale 1ns/1ps
`default_nettype none

module mcfg_board (
   input  wire logic [6:0][7:0]      i_ext,
   input  wire mcfg_pkg::mcfg_pins_t i_pins,
   output logic [6:0][7:0]           o_wire
);
   // ==========================================================
   // Pin resolution
   // ==========================================================
   // Strong external source on released pins, so no level floats
   assign o_wire = (i_ext & i_pins.oe_n) | (i_pins.level & ~i_pins.oe_n);
endmodule // mcfg_board

`default_nettype wire

// file: test/mcfg_bank_tb.sv
// Self-checking bench of the configuration register bank.
// Assumes the pin board model and the bank's package.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
   failures++; $display("Error %s exp %h got %h", nm, ex, got); end end

module mcfg_bank_tb;
   logic                 i_clock = 1'b0;
   logic                 i_reset = 1'b1;
   mcfg_pkg::mcfg_bus_t  bus = '0;
   mcfg_pkg::mcfg_pins_t opins;
   logic [6:0][7:0]      ext = '0;
   logic [6:0][7:0]      pins;
   logic [15:0]          cell_next = '0;
   logic [15:0]          cells;
   logic [7:0]           mlock, blk, comb, combo, rdata, v;
   logic [6:0][7:0]      lin;
   logic [1:0][7:0]      slew;
   logic [1:0]           cfg = 2'h0;
   logic [2:0]           tin;
   logic                 pdown;
   int                   seed = 32'h2A8F311A;
   int                   failures = 0, n_compared = 0, cycles = 0;
   localparam logic [13:0][7:0] RW = {8'h04, 8'h06, 8'h08, 8'h14, 8'h15,
      8'h18, 8'h22, 8'h23, 8'h32, 8'h36, 8'h42, 8'h47, 8'hB4, 8'hC7};

   // ==========================================================
   // Clock, design and board
   // ==========================================================
   always #50 i_clock = ~i_clock;
   mcfg_bank u_mcfg_bank (.i_clock(i_clock), .i_reset(i_reset),
      .i_bus(bus), .i_pins(pins), .i_latched_address(v),
      .i_cell_next(cell_next), .i_comb_terms(comb), .i_main_lock(mlock),
      .i_boot_lock(blk), .i_test_out(comb[2:0]), .i_bus_config(cfg),
      .o_read_data(rdata), .o_pins(opins), .o_fast_slew(slew),
      .o_cells(cells), .o_comb_outputs(combo), .o_logic_inputs(lin),
      .o_logic_strobes(), .o_test_in(tin), .o_power_down(pdown));
   mcfg_board u_mcfg_board (.i_ext(ext), .i_pins(opins), .o_wire(pins));

   // ==========================================================
   // Bus tasks and closing
   // ==========================================================
   task automatic wr(input logic [7:0] off, input logic [7:0] d);
      @(posedge i_clock) bus <= '{1'b1, 1'b0, 1'b1, off, d};
      @(posedge i_clock) bus <= '0;
   endtask
   task automatic rd(input logic [7:0] off, input logic [7:0] ex);
      @(posedge i_clock) bus <= '{1'b1, 1'b1, 1'b0, off, 8'h00};
      @(posedge i_clock) bus <= '0;
      @(negedge i_clock) `CHK("read_data", ex, rdata)
   endtask
   task automatic rst;
      @(posedge i_clock) i_reset <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_reset <= 1'b0;
      repeat (4) @(posedge i_clock);
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Run should take a few hundred cycles
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         report_and_stop();
      end
   end

   // ==========================================================
   // Scenarios
   // ==========================================================
   initial begin
      mlock = $random(seed);
      blk = $random(seed);
      comb = $random(seed);
      for (int p = 0; p < 7; p++) ext[p] = $random(seed);
      rst();
      rd(mcfg_pkg::OFF_PWR_ZERO, 8'h08);
      `CHK("comb_out", comb, combo)
      rd(8'h06, 8'h00);
      wr(mcfg_pkg::OFF_MAIN_LCK, ~mlock);
      rd(mcfg_pkg::OFF_MAIN_LCK, mlock);
      rd(mcfg_pkg::OFF_BOOT_LCK, blk);
      wr(8'h02, 8'hA5);
      rd(8'h02, 8'h00);
      rd(8'hFF, 8'h00);
      for (int i = 0; i < 14; i++) begin
         v = $random(seed);
         wr(RW[i], v);
         rd(RW[i], v);
         if (RW[i] == 8'h18) `CHK("fast_slew", v, slew[0])
      end
      $display("reset and register test done");
      rst();
      for (int p = 0; p < 7; p++) rd(mcfg_pkg::OFF_PIN_IN[p], ext[p]);
      rd(8'h0A, ext[0]);
      rd(8'h1A, ext[3]);
      v = $random(seed);
      wr(8'h06, 8'hFF);
      wr(8'h04, v);
      repeat (2) @(posedge i_clock);
      @(negedge i_clock) `CHK("pin_level", v, opins.level[0])
      `CHK("pin_oe_n", 8'h00, opins.oe_n[0])
      rd(8'h0C, 8'hFF);
      repeat (4) @(posedge i_clock);
      rd(8'h00, v);
      $display("pin test done");
      wr(mcfg_pkg::OFF_BLOCK_A, 8'h0F);
      wr(mcfg_pkg::OFF_CELLS_A, 8'hFF);
      @(negedge i_clock) `CHK("cells", 8'hF0, cells[7:0])
      wr(mcfg_pkg::OFF_CELLS_B, 8'h3C);
      @(negedge i_clock) `CHK("cells_b", 8'h3C, cells[15:8])
      cell_next <= 16'hA55A;
      repeat (3) @(posedge i_clock);
      rd(mcfg_pkg::OFF_CELLS_A, 8'h5A);
      rd(mcfg_pkg::OFF_CELLS_B, 8'hA5);
      wr(mcfg_pkg::OFF_FUNC[6], 8'hFF);
      wr(mcfg_pkg::OFF_TEST_EN, 8'hFF);
      repeat (6) @(posedge i_clock);
      @(negedge i_clock) `CHK("test_in", ext[4][2:0], tin)
      `CHK("test_oe_n", 3'h7, opins.oe_n[4][2:0])
      `CHK("test_out", comb[2:0], opins.level[4][5:3])
      `CHK("addr_out", v, opins.level[6])
      $display("cell and test port test done");
      cfg = 2'h1;
      rst();
      wr(mcfg_pkg::OFF_PWR_ZERO, 8'h0A);
      repeat (14) @(posedge i_clock);
      @(negedge i_clock) `CHK("power_down", 1'b1, pdown)
      rd(mcfg_pkg::OFF_PWR_ZERO, 8'h0A);
      `CHK("power_up", 1'b0, pdown)
      @(negedge i_clock) `CHK("data_port", 8'h0A, opins.level[0])
      `CHK("logic_in", ext[6], lin[6])
      wr(mcfg_pkg::OFF_PWR_TWO, 8'hC4);
      repeat (2) @(negedge i_clock);
      `CHK("logic_block", 8'h00, lin[6])
      wr(mcfg_pkg::OFF_PWR_ZERO, 8'h00);
      repeat (2) @(posedge i_clock);
      cell_next <= 16'h0FF0;
      repeat (3) @(negedge i_clock);
      `CHK("sleep_hold", 16'hA55A, cells)
      ext[0] <= ~ext[0];
      repeat (8) @(negedge i_clock);
      `CHK("sleep_wake", 16'h0FF0, cells)
      $display("power test done");
      report_and_stop();
   end
endmodule // mcfg_bank_tb

`default_nettype wire
